/* File: core/nvm_write_pkg.sv */
// shared constants and types for the nonvolatile memory write control
package nvm_write_pkg;

   // ----------------------------------------------------------------
   // control register layout
   // ----------------------------------------------------------------
   localparam int CTRL_W = 8;
   localparam int WTS_LSB = 4;
   localparam int WTS_MSB = 6;
   localparam int WIP_BIT = 2;
   localparam int WE_BIT = 1;
   localparam int RE_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [2:0] WTS_MAX_CODE = 3'h5;

   // ----------------------------------------------------------------
   // write duration: 18 * 2^(13-code) system clock periods
   // ----------------------------------------------------------------
   localparam int WT_FACTOR = 18;
   localparam int WT_TOP_EXP = 13;
   localparam int WT_CNT_W = 18;
   localparam logic [15:0] IRQ_VECTOR = 16'h000e;
   localparam logic [7:0] AS_DELIVERED = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_DONE = 2'b11
   } wr_state_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } wr_req_type;

endpackage

/* File: core/nvm_array.sv */
// data array of the nonvolatile memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module nvm_array #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   // clock
   input wire logic clk_sys_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [ADDR_W-1:0] wr_addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   // read port
   input wire logic [ADDR_W-1:0] rd_addr_i,
   output logic [DATA_W-1:0] rd_data_o
);
   // as-delivered contents are all zero
   logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1] = '{default: '0};

   always_ff @(posedge clk_sys_i) begin
      if (wr_en_i) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      rd_data_o <= mem_reg[rd_addr_i];
   end
endmodule
`default_nettype wire

/* File: core/nvm_write_control.sv */
// write sequencing, duration timer and write-done request for the nonvolatile memory
`timescale 1ns/100ps
`default_nettype none
// Operation
// - raise a write-done request when one write completes
// - in-progress flag returns to 0 when the write finishes
// - clearing write enable early aborts the write and writes 0 to the target location
// - a write issued during a write is ignored
// - halt does not stop the write
// - stop mode aborts the write, target data undefined
// - clearing write enable mid-write aborts it and forces target to 0
// - memory holds 0 as delivered
// - bits 4..6 select 18*2^13 down to 18*2^8 clocks; others prohibited
// - in-progress flag in bit 2 sets when a write starts
// - reset clears the control register
// - request flag sets when write time elapses; vector 000EH
module nvm_write_control #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // control register write
   input wire logic ctrl_wr_i,
   input wire logic [nvm_write_pkg::CTRL_W-1:0] ctrl_wdata_i,
   // cpu memory access
   input wire logic mem_wr_i,
   input wire logic [ADDR_W-1:0] mem_addr_i,
   input wire logic [DATA_W-1:0] mem_wdata_i,
   // standby modes
   input wire logic halt_i,
   input wire logic stop_i,
   // interrupt flag clear
   input wire logic irq_ack_i,
   // status outputs
   output logic [nvm_write_pkg::CTRL_W-1:0] ctrl_rdata_o,
   output logic [DATA_W-1:0] mem_rdata_o,
   output logic write_done_request_flag_o,
   output logic [15:0] irq_vector_o,
   output logic wts_prohibited_o
);
   import nvm_write_pkg::*;

   // the captured request holds an 8-bit address and an 8-bit data word
   if (ADDR_W < 1 || ADDR_W > 8 || DATA_W != 8) begin : g_bad_params
      $error("nvm_write_control: unsupported parameters");
   end

   // ----------------------------------------------------------------
   // duration decode
   // ----------------------------------------------------------------
   function automatic logic [WT_CNT_W-1:0] cycles_of(input logic [2:0] code);
      logic [WT_CNT_W-1:0] v;
      v = WT_CNT_W'(WT_FACTOR) << (WT_TOP_EXP - int'(code));
      return v;
   endfunction

   logic [2:0] write_time_select_reg;
   logic write_enable_bit_reg;
   logic read_enable_bit_reg;
   logic write_in_progress_flag_reg;
   logic [WT_CNT_W-1:0] count_reg;
   logic write_done_request_flag_reg;
   wr_req_type req_reg;
   wr_state_type state_reg;
   logic arr_wr_reg;
   logic [DATA_W-1:0] arr_data_reg;
   logic accept;
   logic expire;
   logic abort_we;

   assign accept = mem_wr_i && write_enable_bit_reg && !write_in_progress_flag_reg;
   assign expire = write_in_progress_flag_reg && (count_reg == WT_CNT_W'(1));
   assign abort_we = write_in_progress_flag_reg && ctrl_wr_i && !ctrl_wdata_i[WE_BIT];

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         write_time_select_reg <= CTRL_RESET[WTS_MSB:WTS_LSB];
         write_enable_bit_reg <= CTRL_RESET[WE_BIT];
         read_enable_bit_reg <= CTRL_RESET[RE_BIT];
      end else if (ctrl_wr_i) begin
         write_time_select_reg <= ctrl_wdata_i[WTS_MSB:WTS_LSB];
         write_enable_bit_reg <= ctrl_wdata_i[WE_BIT];
         read_enable_bit_reg <= ctrl_wdata_i[RE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // write sequencer and timer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         write_in_progress_flag_reg <= 1'b0;
         count_reg <= '0;
         req_reg <= '0;
         arr_wr_reg <= 1'b0;
         arr_data_reg <= '0;
      end else begin
         arr_wr_reg <= 1'b0;
         case (state_reg)
            ST_IDLE, ST_DONE: begin
               // flag is already low in the done cycle, so a write is taken there too
               if (accept) begin
                  state_reg <= ST_WRITE;
                  write_in_progress_flag_reg <= 1'b1;
                  count_reg <= cycles_of(write_time_select_reg);
                  req_reg.addr <= 8'(mem_addr_i);
                  req_reg.data <= mem_wdata_i;
               end else begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_WRITE: begin
               if (stop_i) begin
                  // abort: target is left untouched, contents undefined
                  state_reg <= ST_IDLE;
                  write_in_progress_flag_reg <= 1'b0;
               end else if (abort_we) begin
                  state_reg <= ST_IDLE;
                  write_in_progress_flag_reg <= 1'b0;
                  arr_wr_reg <= 1'b1;
                  arr_data_reg <= '0;
               end else if (expire) begin
                  state_reg <= ST_DONE;
                  write_in_progress_flag_reg <= 1'b0;
                  arr_wr_reg <= 1'b1;
                  arr_data_reg <= req_reg.data;
               end else begin
                  // halt does not freeze this timer
                  count_reg <= count_reg - WT_CNT_W'(1);
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // write-done request flag, set wins over clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         write_done_request_flag_reg <= 1'b0;
      end else if (expire && state_reg == ST_WRITE && !stop_i && !abort_we) begin
         write_done_request_flag_reg <= 1'b1;
      end else if (irq_ack_i) begin
         write_done_request_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_rdata_o <= CTRL_RESET;
         write_done_request_flag_o <= 1'b0;
         irq_vector_o <= 16'h0000;
         wts_prohibited_o <= 1'b0;
      end else begin
         ctrl_rdata_o <= '0;
         ctrl_rdata_o[WTS_MSB:WTS_LSB] <= write_time_select_reg;
         ctrl_rdata_o[WIP_BIT] <= write_in_progress_flag_reg;
         ctrl_rdata_o[WE_BIT] <= write_enable_bit_reg;
         ctrl_rdata_o[RE_BIT] <= read_enable_bit_reg;
         write_done_request_flag_o <= write_done_request_flag_reg;
         irq_vector_o <= IRQ_VECTOR;
         wts_prohibited_o <= (write_time_select_reg > WTS_MAX_CODE);
      end
   end

   nvm_array #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W)
   ) u_array (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(arr_wr_reg),
      .wr_addr_i(req_reg.addr[ADDR_W-1:0]),
      .wr_data_i(arr_data_reg),
      .rd_addr_i(mem_addr_i),
      .rd_data_o(mem_rdata_o)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_start_sets_flag;
      @(posedge clk_sys_i) disable iff (rst_i)
      accept |=> write_in_progress_flag_reg;
   endproperty
   a_start_sets_flag: assert property (p_start_sets_flag) else $error("flag not set");

   property p_flag_clears;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ST_WRITE && expire && !stop_i && !abort_we) |=> !write_in_progress_flag_reg;
   endproperty
   a_flag_clears: assert property (p_flag_clears) else $error("flag stuck");

   property p_irq_on_done;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ST_WRITE && expire && !stop_i && !abort_we) |=> write_done_request_flag_reg;
   endproperty
   a_irq_on_done: assert property (p_irq_on_done) else $error("no done request");

   property p_ignore_second;
      @(posedge clk_sys_i) disable iff (rst_i)
      (write_in_progress_flag_reg && mem_wr_i) |=> $stable(req_reg);
   endproperty
   a_ignore_second: assert property (p_ignore_second) else $error("second write taken");

   property p_abort_zero;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ST_WRITE && !stop_i && abort_we) |=> (arr_wr_reg && arr_data_reg == '0);
   endproperty
   a_abort_zero: assert property (p_abort_zero) else $error("abort not zero");

   property p_stop_abort;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ST_WRITE && stop_i) |=> (!arr_wr_reg && state_reg == ST_IDLE);
   endproperty
   a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");

   property p_halt_counts;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ST_WRITE && halt_i && !stop_i && !abort_we && !expire)
         |=> count_reg == $past(count_reg) - WT_CNT_W'(1);
   endproperty
   a_halt_counts: assert property (p_halt_counts) else $error("halt froze timer");

   property p_load_count;
      @(posedge clk_sys_i) disable iff (rst_i)
      accept |=> count_reg == cycles_of($past(write_time_select_reg));
   endproperty
   a_load_count: assert property (p_load_count) else $error("bad duration");

   property p_hold_req;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ST_WRITE && $past(state_reg) == ST_WRITE) |-> $stable(req_reg);
   endproperty
   a_hold_req: assert property (p_hold_req) else $error("request changed");
endmodule
`default_nettype wire

/* File: test/nvm_cpu_model.sv */
// cpu core model issuing control writes, memory writes and memory reads
`timescale 1ns/100ps
`default_nettype none
module nvm_cpu_model
   import nvm_write_pkg::*;
(
   // clock and read back
   input wire logic clk_sys_i,
   input wire logic [7:0] mem_rdata_i,
   // requests
   output logic ctrl_wr_o,
   output logic [7:0] ctrl_wdata_o,
   output logic mem_wr_o,
   output logic [7:0] mem_addr_o,
   output logic [7:0] mem_wdata_o
);
   initial begin
      ctrl_wr_o = 1'b0;
      ctrl_wdata_o = 8'h00;
      mem_wr_o = 1'b0;
      mem_addr_o = 8'h00;
      mem_wdata_o = 8'h00;
   end
   // one control word; caller picks code, enables
   task automatic set_ctrl(input logic [2:0] code, input logic we, input logic re);
      @(negedge clk_sys_i);
      ctrl_wdata_o = {1'b0, code, 2'b00, we, re};
      ctrl_wr_o = 1'b1;
      @(negedge clk_sys_i);
      ctrl_wr_o = 1'b0;
      ctrl_wdata_o = ~ctrl_wdata_o;
   endtask
   // one write instruction; data lines scrambled once released
   task automatic mem_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      mem_addr_o = a;
      mem_wdata_o = d;
      mem_wr_o = 1'b1;
      @(negedge clk_sys_i);
      mem_wr_o = 1'b0;
      mem_wdata_o = ~d;
   endtask
   // one read instruction, registered data
   task automatic read_mem(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_i);
      mem_addr_o = a;
      @(negedge clk_sys_i);
      d = mem_rdata_i;
   endtask
endmodule
`default_nettype wire

/* File: test/nvm_write_control_test.sv */
// self-checking bench for the nonvolatile memory write control
`timescale 1ns/100ps
`default_nettype none
module nvm_write_control_test;
   import nvm_write_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic halt_i = 1'b0;
   logic stop_i = 1'b0;
   logic irq_ack_i = 1'b0;
   logic ctrl_wr, mem_wr, req_flag, prohib;
   logic [7:0] ctrl_wdata, mem_addr, mem_wdata, ctrl_rdata, mem_rdata, a, d, r;
   logic [2:0] code;
   logic [15:0] vec;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc;
   always #2.5 clk_sys_i = ~clk_sys_i;
   nvm_write_control uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ctrl_wr_i(ctrl_wr),
      .ctrl_wdata_i(ctrl_wdata), .mem_wr_i(mem_wr), .mem_addr_i(mem_addr),
      .mem_wdata_i(mem_wdata), .halt_i(halt_i), .stop_i(stop_i), .irq_ack_i(irq_ack_i),
      .ctrl_rdata_o(ctrl_rdata), .mem_rdata_o(mem_rdata),
      .write_done_request_flag_o(req_flag), .irq_vector_o(vec), .wts_prohibited_o(prohib));
   nvm_cpu_model cpu (.clk_sys_i(clk_sys_i), .mem_rdata_i(mem_rdata), .ctrl_wr_o(ctrl_wr),
      .ctrl_wdata_o(ctrl_wdata), .mem_wr_o(mem_wr), .mem_addr_o(mem_addr),
      .mem_wdata_o(mem_wdata));
   // expected control image and write duration
   function automatic logic [7:0] img(input logic [2:0] c, input logic w, input logic p);
      return {1'b0, c, 1'b0, p, w, 1'b0};
   endfunction
   function automatic int dur(input logic [2:0] c);
      return WT_FACTOR << (WT_TOP_EXP - int'(c));
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // poll the in-progress flag until it falls, counting cycles
   task automatic wait_idle(output int n);
      n = 0;
      while (ctrl_rdata[WIP_BIT] !== 1'b0) begin
         @(negedge clk_sys_i);
         n++;
         if (n > 20000) begin
            error_cnt++;
            $display("[ERR] %0t flag never fell", $time);
            give_verdict();
         end
      end
   endtask
   initial begin
      void'($urandom(27945));
      repeat (5) @(negedge clk_sys_i);
      rst_i = 1'b0;
      chk(ctrl_rdata, CTRL_RESET);
      @(negedge clk_sys_i);
      chk(vec, IRQ_VECTOR);
      a = 8'($urandom);
      cpu.read_mem(a, r);
      chk(r, AS_DELIVERED);
      $display("reset test done");
      for (int i = 0; i < 3; i++) begin
         code = (i == 1) ? 3'h4 : 3'h5;
         halt_i = 1'($urandom) | (i == 2);
         a = 8'($urandom) & 8'hfe;
         d = 8'($urandom) | 8'h01;
         cpu.set_ctrl(code, 1'b1, 1'b0);
         repeat (2) @(negedge clk_sys_i);
         chk(ctrl_rdata, img(code, 1'b1, 1'b0));
         cpu.mem_write(a, d);
         repeat (2) @(negedge clk_sys_i);
         chk(ctrl_rdata[WIP_BIT], 1'b1);
         cpu.mem_write(a + 8'h01, ~d);
         wait_idle(cyc);
         chk(cyc > dur(code) - 10 && cyc <= dur(code), 1'b1);
         chk(req_flag, 1'b1);
         halt_i = 1'b0;
         cpu.set_ctrl(code, 1'b0, 1'b1);
         cpu.mem_write(a + 8'h01, d);
         repeat (2) @(negedge clk_sys_i);
         chk(ctrl_rdata[WIP_BIT], 1'b0);
         cpu.read_mem(a, r);
         chk(r, d);
         cpu.read_mem(a + 8'h01, r);
         chk(r, AS_DELIVERED);
         irq_ack_i = 1'b1;
         @(negedge clk_sys_i);
         irq_ack_i = 1'b0;
         repeat (2) @(negedge clk_sys_i);
         chk(req_flag, 1'b0);
         $display("write test %0d done", i);
      end
      cpu.set_ctrl(3'h5, 1'b1, 1'b0);
      cpu.mem_write(a, 8'h5a);
      repeat (100) @(negedge clk_sys_i);
      cpu.set_ctrl(3'h5, 1'b0, 1'b0);
      repeat (3) @(negedge clk_sys_i);
      chk(ctrl_rdata[WIP_BIT], 1'b0);
      repeat (dur(3'h5)) @(negedge clk_sys_i);
      chk(req_flag, 1'b0);
      cpu.read_mem(a, r);
      chk(r, 8'h00);
      $display("enable abort test done");
      cpu.set_ctrl(3'h5, 1'b1, 1'b0);
      cpu.mem_write(a, 8'hc3);
      repeat (50) @(negedge clk_sys_i);
      stop_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      stop_i = 1'b0;
      chk(ctrl_rdata[WIP_BIT], 1'b0);
      repeat (dur(3'h5)) @(negedge clk_sys_i);
      chk(req_flag, 1'b0);
      $display("stop abort test done");
      cpu.set_ctrl(3'h6, 1'b0, 1'b0);
      repeat (2) @(negedge clk_sys_i);
      chk(prohib, 1'b1);
      cpu.set_ctrl(3'h5, 1'b0, 1'b0);
      repeat (2) @(negedge clk_sys_i);
      chk(prohib, 1'b0);
      $display("select code test done");
      give_verdict();
   end
endmodule
`default_nettype wire
